/* core/fmd_pkg.sv */
// constants, types and table builders of the fsk modem datapath
// assumes a 50 MHz core clock and a 9.6 kHz sample frame strobe
`default_nettype none

package fmd_pkg;

   typedef logic [7:0] fmd_byte_t;
   typedef logic [31:0] fmd_word_t;
   typedef logic [1:0] fmd_trans_t;
   typedef logic [2:0] fmd_size_t;
   typedef logic signed [15:0] fmd_q_t;
   typedef logic signed [15:0] fmd_cos_tab_t [0:256];

   // bus map, byte addresses of aligned words
   localparam logic [7:0] FMD_OFF_CTRL = 8'h00;
   localparam logic [7:0] FMD_OFF_STATUS = 8'h04;
   localparam logic [7:0] FMD_OFF_TX_SAMPLE = 8'h08;
   localparam logic [7:0] FMD_OFF_RX_SAMPLE = 8'h0C;
   localparam fmd_size_t FMD_HSIZE_WORD = 3'h2;

   // control word fields
   localparam int FMD_CTRL_TX_BIT = 0;
   localparam int FMD_CTRL_TX_MUTE = 1;
   localparam int FMD_CTRL_BELL = 2;
   localparam int FMD_CTRL_ANSWER = 3;
   localparam int FMD_CTRL_GAIN_LSB = 4;
   // status word fields
   localparam int FMD_ST_BAUD_DEC = 0;
   localparam int FMD_ST_SAMPLE_DEC = 1;
   localparam int FMD_ST_BAUD_CNT = 8;
   localparam int FMD_ST_MISMATCH = 16;

   // reset values
   localparam logic FMD_TX_BIT_RESET = 1'b1;
   localparam logic FMD_ANSWER_RESET = 1'b0;
   localparam logic FMD_BELL_RESET = 1'b0;
   localparam logic [1:0] FMD_GAIN_RESET = 2'h0;
   localparam logic [15:0] FMD_PHASE_RESET = 16'h0000;

   // q15 phase encoding, full scale is pi
   localparam logic [15:0] FMD_HALF_PI = 16'h4000;
   localparam int FMD_TABLE_SHIFT = 7;

   // per-sample baud bookkeeping
   localparam logic [5:0] FMD_BAUD_LEN = 6'h20;
   localparam logic [5:0] FMD_MISMATCH_LIM = 6'h20;

   // transmit phase steps, q15 of (f / fs) * 2
   localparam logic [15:0] FMD_V21_ORG_MARK = 16'h1A22;
   localparam logic [15:0] FMD_V21_ORG_SPACE = 16'h1F77;
   localparam logic [15:0] FMD_V21_ANS_MARK = 16'h2C00;
   localparam logic [15:0] FMD_V21_ANS_SPACE = 16'h3155;
   localparam logic [15:0] FMD_B103_ORG_MARK = 16'h21DD;
   localparam logic [15:0] FMD_B103_ORG_SPACE = 16'h1C89;
   localparam logic [15:0] FMD_B103_ANS_MARK = 16'h3B55;
   localparam logic [15:0] FMD_B103_ANS_SPACE = 16'h3600;

   // fractional delay coefficient and gain, q15, per received carrier
   localparam fmd_q_t FMD_V21_ORG_COEFF = 16'sh29FB;
   localparam fmd_q_t FMD_V21_ORG_GAIN = 16'sh5949;
   localparam fmd_q_t FMD_V21_ANS_COEFF = 16'sh582E;
   localparam fmd_q_t FMD_V21_ANS_GAIN = 16'sh7FFF;
   localparam fmd_q_t FMD_B103_ORG_COEFF = 16'sh092F;
   localparam fmd_q_t FMD_B103_ORG_GAIN = 16'sh49E5;
   localparam fmd_q_t FMD_B103_ANS_COEFF = 16'sh288C;
   localparam fmd_q_t FMD_B103_ANS_GAIN = 16'sh7FFF;

   // lowpass iir feedback, q14, plain defaults
   localparam fmd_q_t FMD_LPF_A1 = 16'sh6000;
   localparam fmd_q_t FMD_LPF_A2 = 16'shDC00;
   localparam int FMD_LPF_SHIFT = 14;

   localparam real FMD_PI = 3.14159265358979;

   typedef struct packed {
      fmd_q_t coeff;
      fmd_q_t gain;
      logic low_carrier;
   } fmd_rx_cfg_s;

   function automatic logic [15:0] fmd_tx_step(input logic answer, input logic bell,
                                               input logic mark);
      logic [2:0] sel;
      sel = {bell, answer, mark};
      case (sel)
         3'h0: return FMD_V21_ORG_SPACE;
         3'h1: return FMD_V21_ORG_MARK;
         3'h2: return FMD_V21_ANS_SPACE;
         3'h3: return FMD_V21_ANS_MARK;
         3'h4: return FMD_B103_ORG_SPACE;
         3'h5: return FMD_B103_ORG_MARK;
         3'h6: return FMD_B103_ANS_SPACE;
         default: return FMD_B103_ANS_MARK;
      endcase
   endfunction : fmd_tx_step

   // an answering end hears the low originate carrier
   function automatic fmd_rx_cfg_s fmd_rx_cfg(input logic answer, input logic bell);
      fmd_rx_cfg_s c;
      c.low_carrier = answer;
      case ({bell, answer})
         2'h0: begin
            c.coeff = FMD_V21_ANS_COEFF;
            c.gain = FMD_V21_ANS_GAIN;
         end
         2'h1: begin
            c.coeff = FMD_V21_ORG_COEFF;
            c.gain = FMD_V21_ORG_GAIN;
         end
         2'h2: begin
            c.coeff = FMD_B103_ANS_COEFF;
            c.gain = FMD_B103_ANS_GAIN;
         end
         default: begin
            c.coeff = FMD_B103_ORG_COEFF;
            c.gain = FMD_B103_ORG_GAIN;
         end
      endcase
      return c;
   endfunction : fmd_rx_cfg

   // cos(k * pi / 256) in q15, built at elaboration by series expansion
   function automatic fmd_cos_tab_t fmd_build_cos();
      fmd_cos_tab_t t;
      real x;
      real term;
      real sum;
      int q;
      for (int k = 0; k <= 256; k++) begin
         x = FMD_PI * k / 256.0;
         term = 1.0;
         sum = 1.0;
         for (int n = 1; n <= 14; n++) begin
            term = -term * x * x / ((2.0 * n - 1.0) * (2.0 * n));
            sum = sum + term;
         end
         q = $rtoi(sum * 32768.0 + ((sum >= 0.0) ? 0.5 : -0.5));
         if (q > 32767) begin
            q = 32767;
         end
         if (q < -32768) begin
            q = -32768;
         end
         t[k] = 16'(q);
      end
      return t;
   endfunction : fmd_build_cos

endpackage : fmd_pkg

`default_nettype wire

/* core/fmd_codec_if.sv */
// carrier between the datapath core and its compander
// assumes both ends live in the same clock domain
`timescale 1ns/1ps
`default_nettype none

interface fmd_codec_if;
   logic [7:0] rx_code;
   logic signed [12:0] rx_linear;
   logic signed [11:0] tx_linear;
   logic [7:0] tx_code;
   modport compander(input rx_code, input tx_linear, output rx_linear, output tx_code);
   modport core(output rx_code, output tx_linear, input rx_linear, input tx_code);
endinterface : fmd_codec_if

`default_nettype wire

/* core/fmd_compander.sv */
// combinational a-law style compander: 8-bit code to 13-bit linear, 12-bit linear to 8-bit code
// assumes the caller registers both directions
`timescale 1ns/1ps
`default_nettype none

module fmd_compander (
   fmd_codec_if.compander cif
);
   import fmd_pkg::*;

   localparam logic [7:0] EVEN_BITS = 8'h55;

   function automatic logic signed [12:0] expand(input logic [7:0] code_in);
      logic [7:0] c;
      logic [11:0] mag;
      c = code_in ^ EVEN_BITS;
      if (c[6:4] == 3'h0) begin
         mag = {7'h00, c[3:0], 1'b1};
      end else begin
         mag = {6'h00, 1'b1, c[3:0], 1'b1} << (c[6:4] - 3'h1);
      end
      // set sign bit means positive
      return c[7] ? $signed({1'b0, mag}) : -$signed({1'b0, mag});
   endfunction : expand

   function automatic logic [7:0] compress(input logic signed [11:0] v);
      logic [12:0] ext;
      logic [11:0] mag;
      logic [2:0] ex;
      logic [3:0] mant;
      ext = {v[11], v};
      ext = v[11] ? (~ext + 13'h0001) : ext;
      mag = ext[11:0];
      ex = 3'h0;
      mant = mag[4:1];
      for (int i = 1; i <= 7; i++) begin
         if (mag[i + 4]) begin
            ex = 3'(i);
            mant = 4'(mag >> i);
         end
      end
      return {~v[11], ex, mant} ^ EVEN_BITS;
   endfunction : compress

   always_comb begin
      cif.rx_linear = expand(cif.rx_code);
      cif.tx_code = compress(cif.tx_linear);
   end

endmodule : fmd_compander

`default_nettype wire

/* core/fsk_modem_datapath.sv */
// fsk modem datapath: phase-continuous tone generator, delay-and-multiply
// demodulator and baud decision, one step per codec frame, ahb-lite registers
// assumes a frame strobe and 8-bit codec codes from pins, one 50 MHz clock
//
// The address map and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module fsk_modem_datapath (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic ce,
   input wire logic hsel,
   input wire fmd_pkg::fmd_word_t haddr,
   input wire fmd_pkg::fmd_trans_t htrans,
   input wire logic hwrite,
   input wire fmd_pkg::fmd_size_t hsize,
   input wire fmd_pkg::fmd_word_t hwdata,
   input wire logic hready,
   output logic hreadyout,
   output fmd_pkg::fmd_word_t hrdata,
   output logic hresp,
   input wire logic codec_frame,
   input wire fmd_pkg::fmd_byte_t codec_rx_byte,
   output fmd_pkg::fmd_byte_t codec_tx_byte,
   output logic baud_start,
   output logic rx_data
);
   import fmd_pkg::*;

   localparam fmd_cos_tab_t cosine_table_base = fmd_build_cos();

   typedef struct packed {
      logic [2:0] frame_sync;
      logic frame_level;
      logic [7:0] rx_code_s1;
      logic [7:0] rx_code_s2;
      logic [7:0] rx_code_s3;
      logic tick_dly;
      logic ctrl_answer;
      logic ctrl_bell;
      logic ctrl_tx_bit;
      logic ctrl_tx_mute;
      logic [1:0] ctrl_gain;
      logic [15:0] tx_phase_acc;
      logic [15:0] tx_phase_step;
      logic signed [11:0] tx_sample;
      logic [7:0] codec_tx_byte;
      logic baud_start;
      logic signed [15:0] gain_adjusted_sample;
      logic signed [15:0] delay_tap_first;
      logic signed [15:0] delay_tap_second;
      logic signed [15:0] delay_tap_third;
      logic signed [15:0] demod_product;
      logic signed [15:0] lowpass_output;
      logic signed [15:0] lowpass_prev;
      logic sample_decision;
      logic baud_decision;
      logic [5:0] baud_sample_count;
      logic [5:0] mismatch_count;
      logic dp_wr_ctrl;
      logic [31:0] hrdata;
      logic hreadyout;
      logic hresp;
   } fmd_state_s;

   function automatic fmd_state_s reset_state();
      fmd_state_s s;
      s = '0;
      s.ctrl_answer = FMD_ANSWER_RESET;
      s.ctrl_bell = FMD_BELL_RESET;
      s.ctrl_tx_bit = FMD_TX_BIT_RESET;
      s.ctrl_gain = FMD_GAIN_RESET;
      s.tx_phase_acc = FMD_PHASE_RESET;
      s.tx_phase_step = fmd_tx_step(FMD_ANSWER_RESET, FMD_BELL_RESET, FMD_TX_BIT_RESET);
      s.hreadyout = 1'b1;
      return s;
   endfunction : reset_state

   localparam fmd_state_s STATE_RESET = reset_state();

   // signed product shifted back to the operand's q format
   function automatic logic signed [31:0] mul_shift(input logic signed [15:0] a,
                                                    input logic signed [15:0] b,
                                                    input int sh);
      logic signed [31:0] p;
      p = a * b;
      return p >>> sh;
   endfunction : mul_shift

   function automatic logic signed [15:0] sat16(input logic signed [33:0] v);
      if (v > 34'sd32767) begin
         return 16'sh7FFF;
      end else if (v < -34'sd32768) begin
         return 16'sh8000;
      end
      return v[15:0];
   endfunction : sat16

   // angle minus half pi, folded by absolute value onto zero to pi
   function automatic logic signed [11:0] sine_lookup(input logic [15:0] phase);
      logic [15:0] ang;
      logic [15:0] mag;
      logic [8:0] idx;
      ang = phase - FMD_HALF_PI;
      mag = ang[15] ? (~ang + 16'h0001) : ang;
      idx = mag[15:FMD_TABLE_SHIFT];
      return cosine_table_base[idx][15:4];
   endfunction : sine_lookup

   fmd_state_s st_q;
   fmd_state_s st_d;
   fmd_rx_cfg_s rx_cfg;
   logic tick;
   logic frame_agree;
   logic signed [15:0] gain_in;
   logic signed [15:0] delayed;
   logic signed [15:0] scaled;
   logic signed [15:0] lp_new;
   logic est;
   logic [5:0] mis_next;
   logic [5:0] cnt_next;
   logic [31:0] rd_word;

   fmd_codec_if u_cif ();

   fmd_compander u_compander (
      .cif(u_cif)
   );

   assign u_cif.rx_code = st_q.rx_code_s3;
   assign u_cif.tx_linear = st_q.tx_sample;

   always_comb begin
      st_d = st_q;
      rx_cfg = fmd_rx_cfg(st_q.ctrl_answer, st_q.ctrl_bell);
      gain_in = '0;
      delayed = '0;
      scaled = '0;
      lp_new = '0;
      est = 1'b0;
      mis_next = st_q.mismatch_count;
      cnt_next = st_q.baud_sample_count;
      rd_word = '0;

      // pin synchronisers; a frame edge counts once stages two and three agree
      st_d.frame_sync = {st_q.frame_sync[1:0], codec_frame};
      st_d.rx_code_s1 = codec_rx_byte;
      st_d.rx_code_s2 = st_q.rx_code_s1;
      st_d.rx_code_s3 = st_q.rx_code_s2;
      frame_agree = st_q.frame_sync[1] == st_q.frame_sync[2];
      tick = frame_agree && st_q.frame_sync[2] && !st_q.frame_level;
      if (frame_agree) begin
         st_d.frame_level = st_q.frame_sync[2];
      end
      st_d.tick_dly = tick;
      st_d.baud_start = 1'b0;

      // compressed code of the sample made on this step, taken one clock after its tick
      if (st_q.tick_dly) begin
         st_d.codec_tx_byte = u_cif.tx_code;
      end

      if (tick) begin
         // transmit
         if (st_q.baud_sample_count == '0) begin
            st_d.tx_phase_step = fmd_tx_step(st_q.ctrl_answer, st_q.ctrl_bell,
                                             st_q.ctrl_tx_bit);
            st_d.baud_start = 1'b1;
         end
         st_d.tx_phase_acc = st_q.tx_phase_acc + st_d.tx_phase_step;
         st_d.tx_sample = st_q.ctrl_tx_mute ? 12'sh000 : sine_lookup(st_d.tx_phase_acc);

         // receive: linear code to q11, then coarse gain shift
         gain_in = {{3{u_cif.rx_linear[12]}}, u_cif.rx_linear};
         gain_in = sat16(34'(gain_in) <<< st_q.ctrl_gain);
         st_d.gain_adjusted_sample = gain_in;

         delayed = rx_cfg.low_carrier ? st_q.delay_tap_third : st_q.delay_tap_second;
         st_d.demod_product = sat16(34'(mul_shift(gain_in, delayed, 11)));
         scaled = sat16(34'(mul_shift(st_d.demod_product, rx_cfg.gain, 15)));
         lp_new = sat16(34'(scaled)
                        + 34'(mul_shift(st_q.lowpass_output, FMD_LPF_A1, FMD_LPF_SHIFT))
                        + 34'(mul_shift(st_q.lowpass_prev, FMD_LPF_A2, FMD_LPF_SHIFT)));
         st_d.lowpass_prev = st_q.lowpass_output;
         st_d.lowpass_output = lp_new;

         if (rx_cfg.low_carrier) begin
            st_d.delay_tap_third = st_q.delay_tap_second;
         end
         st_d.delay_tap_second = sat16(34'(gain_in)
                                       + 34'(mul_shift(st_q.delay_tap_first, rx_cfg.coeff,
                                                       15)));
         st_d.delay_tap_first = gain_in;

         // v.21 has negative deviation, so its sign reads inverted
         est = (~lp_new[15]) ^ (~st_q.ctrl_bell);
         st_d.sample_decision = est;

         // baud decision
         mis_next = st_q.mismatch_count + {5'h00, est != st_q.baud_decision};
         cnt_next = st_q.baud_sample_count + 6'h01;
         if (mis_next == FMD_MISMATCH_LIM) begin
            st_d.baud_decision = ~st_q.baud_decision;
            mis_next = '0;
         end
         if (cnt_next == FMD_BAUD_LEN) begin
            cnt_next = '0;
            mis_next = '0;
         end
         st_d.mismatch_count = mis_next;
         st_d.baud_sample_count = cnt_next;
      end

      // ahb-lite slave, zero wait states, always okay
      st_d.hreadyout = 1'b1;
      st_d.hresp = 1'b0;
      if (st_q.dp_wr_ctrl) begin
         st_d.ctrl_tx_bit = hwdata[FMD_CTRL_TX_BIT];
         st_d.ctrl_tx_mute = hwdata[FMD_CTRL_TX_MUTE];
         st_d.ctrl_bell = hwdata[FMD_CTRL_BELL];
         st_d.ctrl_answer = hwdata[FMD_CTRL_ANSWER];
         st_d.ctrl_gain = hwdata[FMD_CTRL_GAIN_LSB +: 2];
      end
      st_d.dp_wr_ctrl = 1'b0;
      if (hsel && htrans[1] && hready) begin
         if (hwrite) begin
            st_d.dp_wr_ctrl = (haddr[7:0] == FMD_OFF_CTRL) && (hsize == FMD_HSIZE_WORD);
         end else begin
            // read from the next state so a write just ending is seen
            case (haddr[7:0])
               FMD_OFF_CTRL: begin
                  rd_word[FMD_CTRL_TX_BIT] = st_d.ctrl_tx_bit;
                  rd_word[FMD_CTRL_TX_MUTE] = st_d.ctrl_tx_mute;
                  rd_word[FMD_CTRL_BELL] = st_d.ctrl_bell;
                  rd_word[FMD_CTRL_ANSWER] = st_d.ctrl_answer;
                  rd_word[FMD_CTRL_GAIN_LSB +: 2] = st_d.ctrl_gain;
               end
               FMD_OFF_STATUS: begin
                  rd_word[FMD_ST_BAUD_DEC] = st_d.baud_decision;
                  rd_word[FMD_ST_SAMPLE_DEC] = st_d.sample_decision;
                  rd_word[FMD_ST_BAUD_CNT +: 6] = st_d.baud_sample_count;
                  rd_word[FMD_ST_MISMATCH +: 6] = st_d.mismatch_count;
               end
               FMD_OFF_TX_SAMPLE: begin
                  rd_word[11:0] = st_d.tx_sample;
               end
               FMD_OFF_RX_SAMPLE: begin
                  rd_word[15:0] = st_d.gain_adjusted_sample;
               end
               default: begin
                  rd_word = '0;
               end
            endcase
            st_d.hrdata = rd_word;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= STATE_RESET;
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   assign hreadyout = st_q.hreadyout;
   assign hrdata = st_q.hrdata;
   assign hresp = st_q.hresp;
   assign codec_tx_byte = st_q.codec_tx_byte;
   assign baud_start = st_q.baud_start;
   assign rx_data = st_q.baud_decision;

endmodule : fsk_modem_datapath

`default_nettype wire

/* tb/fmd_chk.sv */
// port-level checker of the fsk modem datapath
// assumes one clock domain and the async active-low reset of the top module
`timescale 1ns/1ps
`default_nettype none

module fmd_chk
   import fmd_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic hsel,
   input wire fmd_word_t haddr,
   input wire fmd_trans_t htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire fmd_word_t hrdata,
   input wire logic hresp,
   input wire logic codec_frame,
   input wire fmd_byte_t codec_tx_byte,
   input wire logic baud_start,
   input wire logic rx_data
);
   logic frame_q, rd_q, unm_q, seen_q;
   logic [7:0] hist_q;
   logic [6:0] steps_q;
   wire logic rd_take;
   assign rd_take = hsel & htrans[1] & hready & ~hwrite;

   // frame edge history and step count since the last baud start
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         frame_q <= 1'b0;
         rd_q <= 1'b0;
         unm_q <= 1'b0;
         seen_q <= 1'b0;
         hist_q <= 8'h00;
         steps_q <= 7'h00;
      end else begin
         frame_q <= codec_frame;
         rd_q <= rd_take;
         unm_q <= rd_take & (haddr[7:0] > 8'h0C);
         seen_q <= seen_q | baud_start;
         hist_q <= {hist_q[6:0], codec_frame & ~frame_q};
         if (baud_start) begin
            steps_q <= 7'h00;
         end else if (codec_frame & ~frame_q) begin
            steps_q <= steps_q + 7'h01;
         end
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence s_step;
      |hist_q[5:2];
   endsequence
   sequence s_pulse;
      baud_start ##1 !baud_start;
   endsequence

   property p_ready;
      hreadyout && !hresp;
   endproperty
   property p_hrdata;
      $changed(hrdata) |-> rd_q;
   endproperty
   property p_unmapped;
      unm_q |-> hrdata == 32'h0;
   endproperty
   property p_baud_pulse;
      baud_start |-> s_pulse;
   endproperty
   property p_baud_when;
      baud_start |-> s_step;
   endproperty
   property p_baud_period;
      baud_start |-> !seen_q || steps_q == 7'h20;
   endproperty
   property p_tx_when;
      $changed(codec_tx_byte) |-> s_step;
   endproperty
   property p_rx_when;
      $changed(rx_data) |-> steps_q == 7'h1F ##0 s_step;
   endproperty

   a_ready: assert property (p_ready) else $error("slave not ready or not okay");
   a_hrdata: assert property (p_hrdata) else $error("read data moved without a read");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_baud_pulse: assert property (p_baud_pulse) else $error("baud start too long");
   a_baud_when: assert property (p_baud_when) else $error("baud start off a step");
   a_baud_period: assert property (p_baud_period) else $error("baud not 32 steps");
   a_tx_when: assert property (p_tx_when) else $error("tx code moved off a step");
   a_rx_when: assert property (p_rx_when) else $error("decision moved mid baud");
endmodule : fmd_chk

bind fsk_modem_datapath fmd_chk i_chk (.clk, .rst_b, .hsel, .haddr, .htrans, .hwrite,
   .hready, .hreadyout, .hrdata, .hresp, .codec_frame, .codec_tx_byte, .baud_start, .rx_data);

`default_nettype wire

/* tb/fmd_codec_model.sv */
// codec side of the datapath: frame strobe and received codes
// assumes the bench calls send once per sample period
`timescale 1ns/1ps
`default_nettype none

module fmd_codec_model
   import fmd_pkg::*;
(
   input wire logic clk,
   output logic codec_frame,
   output fmd_byte_t codec_rx_byte,
   input wire fmd_byte_t codec_tx_byte
);
   fmd_byte_t last_tx;

   initial begin
      codec_frame = 1'b0;
      codec_rx_byte = 8'h00;
   end

   // code stands 3 clk before and 4 clk after the frame edge, then is scrambled
   task send(input fmd_byte_t b);
      @(posedge clk);
      codec_rx_byte <= b;
      repeat (3) @(posedge clk);
      codec_frame <= 1'b1;
      repeat (4) @(posedge clk);
      codec_rx_byte <= ~b;
      repeat (6) @(posedge clk);
      codec_frame <= 1'b0;
      repeat (6) @(posedge clk);
      last_tx <= codec_tx_byte;
   endtask : send
endmodule : fmd_codec_model

`default_nettype wire

/* tb/fsk_modem_datapath_tb.sv */
// self-checking bench of the fsk modem datapath
// assumes the codec model in tb and the checker bound to the top module
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("[FAIL] %s exp %h got %h", nm, e, g); end end

module fsk_modem_datapath_tb;
   import fmd_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   fmd_word_t haddr = '0;
   fmd_word_t hwdata = '0;
   fmd_word_t rd;
   fmd_trans_t htrans = 2'h0;
   fmd_size_t hsize = FMD_HSIZE_WORD;
   wire logic hreadyout, hresp, baud_start, rx_data, codec_frame;
   wire fmd_word_t hrdata;
   wire fmd_byte_t codec_tx_byte, codec_rx_byte;
   int num_errors = 0;
   int n_checks = 0;
   int cycles = 0;
   logic [15:0] phase = 16'h0000;
   logic [15:0] step = FMD_V21_ORG_MARK;
   logic rxd = 1'b0;
   logic [5:0] cnt = 6'h00;
   logic [5:0] mis = 6'h00;
   localparam logic [15:0] STEPS [8] = '{FMD_V21_ORG_SPACE, FMD_V21_ORG_MARK,
      FMD_V21_ANS_SPACE, FMD_V21_ANS_MARK, FMD_B103_ORG_SPACE, FMD_B103_ORG_MARK,
      FMD_B103_ANS_SPACE, FMD_B103_ANS_MARK};

   fsk_modem_datapath i_dut (.clk, .rst_b, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .codec_frame,
      .codec_rx_byte, .codec_tx_byte, .baud_start, .rx_data);
   fmd_codec_model i_codec (.clk, .codec_frame, .codec_rx_byte, .codec_tx_byte);

   initial begin
      forever #10 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         num_errors++;
         give_verdict();
      end
   end

   task give_verdict();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : give_verdict

   // one single-word transfer, read data left in rd
   task automatic bus(input logic w, input logic [7:0] a, input fmd_word_t d,
                      input fmd_size_t sz);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= sz;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus

   function automatic logic [11:0] exp_smp(input logic [15:0] ph);
      logic [15:0] a;
      real v;
      int q;
      a = ph - FMD_HALF_PI;
      if (a[15]) a = -a;
      v = $cos(3.14159265358979 * (a >> 7) / 256.0) * 32768.0;
      q = $rtoi(v + ((v >= 0.0) ? 0.5 : -0.5));
      if (q > 32767) q = 32767;
      return 12'(q >>> 4);
   endfunction : exp_smp

   // a-law style code of a 12-bit sample, sign bit set for positive
   function automatic logic [7:0] exp_code(input logic [11:0] v);
      logic [11:0] m;
      logic [2:0] e;
      m = v[11] ? -v : v;
      e = 3'h0;
      for (int i = 1; i <= 7; i++) begin
         if (m[i + 4]) e = 3'(i);
      end
      return {~v[11], e, 4'(m >> ((e == 3'h0) ? 3'h1 : e))} ^ 8'h55;
   endfunction : exp_code

   task t_reset();
      bus(1'b0, FMD_OFF_CTRL, 32'h0, FMD_HSIZE_WORD);
      `CHK("ctrl", 32'h1, rd)
      bus(1'b0, FMD_OFF_STATUS, 32'h0, FMD_HSIZE_WORD);
      `CHK("status", 32'h0, rd)
      bus(1'b0, FMD_OFF_TX_SAMPLE, 32'h0, FMD_HSIZE_WORD);
      `CHK("tx_sample", 32'h0, rd)
      `CHK("codec_tx_byte", 8'h00, codec_tx_byte)
      `CHK("rx_data", 1'b0, rx_data)
   endtask : t_reset

   // read-back, refused writes and an unmapped read
   task t_regs();
      bus(1'b1, FMD_OFF_CTRL, 32'h3F, FMD_HSIZE_WORD);
      bus(1'b1, FMD_OFF_CTRL, 32'h0, 3'h0);
      bus(1'b0, FMD_OFF_CTRL, 32'h0, FMD_HSIZE_WORD);
      `CHK("ctrl", 32'h3F, rd)
      bus(1'b1, FMD_OFF_STATUS, 32'hFFFFFFFF, FMD_HSIZE_WORD);
      bus(1'b0, FMD_OFF_STATUS, 32'h0, FMD_HSIZE_WORD);
      `CHK("status", 32'h0, rd)
      bus(1'b0, 8'h10, 32'h0, FMD_HSIZE_WORD);
      `CHK("unmapped", 32'h0, rd)
      bus(1'b1, FMD_OFF_CTRL, 32'h1, FMD_HSIZE_WORD);
   endtask : t_regs

   // every mode and bit for one baud each, then back to the first
   task t_stream();
      logic [2:0] c;
      for (int b = 0; b < 9; b++) begin
         c = 3'(b % 8);
         bus(1'b1, FMD_OFF_CTRL, {28'h0, c[1], c[2], 1'b0, c[0]}, FMD_HSIZE_WORD);
         for (int s = 0; s < 32; s++) begin
            if (cnt == 6'h00) step = STEPS[c];
            phase = phase + step;
            if (c[2] != rxd) mis++;
            cnt++;
            if (cnt == 6'h20) begin
               if (mis == 6'h20) rxd = ~rxd;
               cnt = 6'h00;
               mis = 6'h00;
            end
            i_codec.send(8'hD5);
            bus(1'b0, FMD_OFF_TX_SAMPLE, 32'h0, FMD_HSIZE_WORD);
            `CHK("tx_sample", {20'h0, exp_smp(phase)}, rd)
            bus(1'b0, FMD_OFF_STATUS, 32'h0, FMD_HSIZE_WORD);
            `CHK("status", {10'h0, mis, 2'h0, cnt, 6'h0, c[2], rxd}, rd)
            `CHK("rx_data", rxd, rx_data)
            `CHK("codec_tx_byte", exp_code(exp_smp(phase)), i_codec.last_tx)
         end
      end
      bus(1'b0, FMD_OFF_RX_SAMPLE, 32'h0, FMD_HSIZE_WORD);
      `CHK("rx_sample", 32'h1, rd)
   endtask : t_stream

   initial begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      t_reset();
      t_regs();
      t_stream();
      give_verdict();
   end
endmodule : fsk_modem_datapath_tb

`default_nettype wire
